// [ldsc_serial_config.sv]
// Purpose: serial front end of a 24-channel led driver: shift register,
//          frame decode on the load strobe, configuration latches
// Assumes: i_rst is the power-on reset; shift clock idles around strobes
// Notes: shift logic runs on i_shift_clk, decode and latches on i_clk
`timescale 1ns/1ps
`include "ldsc_consts.svh"

module ldsc_serial_config
    import ldsc_pkg::*;
(
    input wire logic i_clk, // system clock, 250 MHz
    input wire logic i_rst, // power-on reset, async, high
    input wire logic i_shift_clk, // serial shift clock from host
    input wire logic i_serial_in, // serial data into bit 0
    input wire logic i_load_strobe, // load strobe pin
    input wire logic i_overtemp, // thermal sensor trip, async
    input wire logic i_led_fault, // open/short or pwm error, async
    output logic o_serial_out, // bit 287 of shift register
    output logic o_fault_pulldown_out, // fault pin drive value (low)
    output logic o_fault_pulldown_oe, // fault pin pulled low when high
    output logic o_outputs_allowed, // low while thermal fault active
    output logic [12:0] o_function_control, // function control field
    output logic [23:0] o_group_brightness, // b,g,r brightness bytes
    output logic [167:0] o_dot_correction, // 24 x 7-bit correction
    output logic [287:0] o_grayscale, // grayscale latch
    output logic o_led_fault_mask, // led faults kept off fault pin
    output logic o_edge_speed_select, // 1: fast output edges
    output logic o_open_threshold_select, // 1: higher open threshold
    output logic o_short_threshold_select, // 1: wider short threshold
    output logic o_neighbour_test_current, // 1: higher test current
    output logic o_neighbour_test_duration, // 1: longer test time
    output ldsc_cw_e o_counter_width, // grayscale counter width
    output logic o_timing_reset_en, // display-timing reset mode
    output logic o_auto_repeat_en, // automatic display repeat
    output logic [2:0] o_correction_span, // b,g,r span select
    output logic o_thermal_fault_flag, // latched overtemperature
    output logic o_led_fault_flag // latched led fault
);

    // ----------------------------------------------------------------
    // link domain: common shift register
    // ----------------------------------------------------------------
    logic [287:0] sreg_q;
    logic strobe_at_edge_q;
    logic rl_sync1_q;
    logic rl_sync2_q;
    logic rl_seen_q;
    logic out_q;

    // system-domain side of the reload handshake
    logic [287:0] reload_word_q;
    logic reload_tgl_q;

    // shift one bit per edge; a reload lands at the third edge, keeping
    // the two bits already shifted in so the new frame stays whole
    always_ff @(posedge i_shift_clk or posedge i_rst) begin
        if (i_rst) begin
            sreg_q <= '0;
        end else if (rl_sync2_q != rl_seen_q) begin
            sreg_q <= {reload_word_q[`LDSC_FRAME_W - 4:0], sreg_q[1:0], i_serial_in};
        end else begin
            sreg_q <= {sreg_q[286:0], i_serial_in};
        end
    end

    // serial out is the top bit, registered so it leaves a flop
    always_ff @(posedge i_shift_clk or posedge i_rst) begin
        if (i_rst) begin
            out_q <= 1'b0;
        end else if (rl_sync2_q != rl_seen_q) begin
            out_q <= reload_word_q[`LDSC_FRAME_W - 4];
        end else begin
            out_q <= sreg_q[`LDSC_FRAME_W - 2];
        end
    end

    // strobe level at each edge; the last one before the rise decides
    always_ff @(posedge i_shift_clk or posedge i_rst) begin
        if (i_rst) begin
            strobe_at_edge_q <= 1'b0;
        end else begin
            strobe_at_edge_q <= i_load_strobe;
        end
    end

    // reload toggle crossing into the link domain
    always_ff @(posedge i_shift_clk or posedge i_rst) begin
        if (i_rst) begin
            rl_sync1_q <= 1'b0;
            rl_sync2_q <= 1'b0;
            rl_seen_q <= 1'b0;
        end else begin
            rl_sync1_q <= reload_tgl_q;
            rl_sync2_q <= rl_sync1_q;
            rl_seen_q <= rl_sync2_q;
        end
    end

    assign o_serial_out = out_q;

    // ----------------------------------------------------------------
    // system domain: pin synchronisers
    // ----------------------------------------------------------------
    logic stb_s1_q;
    logic stb_s2_q;
    logic stb_s3_q;
    logic ot_s1_q;
    logic ot_s2_q;
    logic lf_s1_q;
    logic lf_s2_q;

    // two flops per pin; the third strobe flop only feeds edge detect
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            stb_s1_q <= 1'b0;
            stb_s2_q <= 1'b0;
            stb_s3_q <= 1'b0;
            ot_s1_q <= 1'b0;
            ot_s2_q <= 1'b0;
            lf_s1_q <= 1'b0;
            lf_s2_q <= 1'b0;
        end else begin
            stb_s1_q <= i_load_strobe;
            stb_s2_q <= stb_s1_q;
            stb_s3_q <= stb_s2_q;
            ot_s1_q <= i_overtemp;
            ot_s2_q <= ot_s1_q;
            lf_s1_q <= i_led_fault;
            lf_s2_q <= lf_s1_q;
        end
    end

    logic strobe_rise;
    assign strobe_rise = stb_s2_q & ~stb_s3_q;

    // ----------------------------------------------------------------
    // frame capture and decode
    // ----------------------------------------------------------------
    // the shift clock is idle while the strobe is high, so sreg_q and
    // strobe_at_edge_q are quasi-static when the synced rise arrives
    ldsc_st_e st_q;
    logic [287:0] frame_q;
    logic frame_cmd_q;

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            st_q <= LDSC_ST_IDLE;
            frame_q <= '0;
            frame_cmd_q <= 1'b0;
        end else begin
            case (st_q)
                LDSC_ST_IDLE: begin
                    if (strobe_rise) begin
                        frame_q <= sreg_q;
                        frame_cmd_q <= strobe_at_edge_q;
                        st_q <= LDSC_ST_DECODE;
                    end
                end
                LDSC_ST_DECODE: begin
                    st_q <= LDSC_ST_RELOAD;
                end
                default: begin
                    st_q <= LDSC_ST_IDLE;
                end
            endcase
        end
    end

    logic [11:0] code;
    logic is_decode;
    logic do_gs;
    logic do_cfg;
    logic do_errclr;
    logic do_grst;
    logic do_neg;
    logic known_cmd;

    assign code = frame_q[`LDSC_CMD_HI:`LDSC_CMD_LO];
    assign is_decode = (st_q == LDSC_ST_DECODE);

    // command table; any code outside it, zero included, is the plain configuration write
    assign known_cmd = (code == `LDSC_CMD_GS_RD) | (code == `LDSC_CMD_SID_RD)
        | (code == `LDSC_CMD_CFG_RD) | (code == `LDSC_CMD_NBR) | (code == `LDSC_CMD_SELF)
        | (code == `LDSC_CMD_NEG) | (code == `LDSC_CMD_ERRCLR) | (code == `LDSC_CMD_GRST);

    assign do_gs = is_decode & ~frame_cmd_q;
    assign do_cfg = is_decode & frame_cmd_q & ~known_cmd;
    assign do_errclr = is_decode & frame_cmd_q & (code == `LDSC_CMD_ERRCLR);
    assign do_grst = is_decode & frame_cmd_q & (code == `LDSC_CMD_GRST);
    assign do_neg = is_decode & frame_cmd_q & (code == `LDSC_CMD_NEG);

    // ----------------------------------------------------------------
    // configuration and grayscale latches
    // ----------------------------------------------------------------
    logic [12:0] fc_q;
    logic [23:0] bc_q;
    logic [167:0] dc_q;
    logic [287:0] gs_q;
    logic neg_q;

    // config write: only the low 205 bits land; high bits ignored
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            fc_q <= `LDSC_FC_RESET;
            bc_q <= '0;
            dc_q <= '0;
        end else if (do_grst) begin
            fc_q <= `LDSC_FC_RESET;
            bc_q <= '0;
            dc_q <= '0;
        end else if (do_cfg) begin
            fc_q <= frame_q[`LDSC_FC_HI:`LDSC_FC_LO];
            bc_q <= frame_q[`LDSC_BC_HI:`LDSC_BC_LO];
            dc_q <= frame_q[`LDSC_DC_HI:`LDSC_DC_LO];
        end
    end

    // grayscale latch untouched by config writes and by commands other than global reset, which clears it
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            gs_q <= '0;
        end else if (do_grst) begin
            gs_q <= '0;
        end else if (do_gs) begin
            gs_q <= frame_q;
        end
    end

    // negate bit toggles on its command
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            neg_q <= 1'b0;
        end else if (do_grst) begin
            neg_q <= 1'b0;
        end else if (do_neg) begin
            neg_q <= ~neg_q;
        end
    end

    // ----------------------------------------------------------------
    // fault flags
    // ----------------------------------------------------------------
    logic tef_q;
    logic lfault_q;

    // sticky flags; a fault still present at clear time keeps the flag
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            tef_q <= 1'b0;
            lfault_q <= 1'b0;
        end else begin
            if (ot_s2_q) begin
                tef_q <= 1'b1;
            end else if (do_errclr | do_grst) begin
                tef_q <= 1'b0;
            end
            if (lf_s2_q) begin
                lfault_q <= 1'b1;
            end else if (do_errclr | do_grst) begin
                lfault_q <= 1'b0;
            end
        end
    end

    // fault pin and output shutdown, all from flops
    logic pd_q;
    logic allow_q;

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            pd_q <= 1'b0;
            allow_q <= 1'b0;
        end else begin
            pd_q <= tef_q | (lfault_q & ~fc_q[`LDSC_FC_MASK]);
            allow_q <= ~tef_q & ~ot_s2_q;
        end
    end

    // ----------------------------------------------------------------
    // readback: word handed to the link domain after a strobe
    // ----------------------------------------------------------------
    logic [287:0] sid_word;
    logic [287:0] cfg_word;

    always_comb begin
        sid_word = '0;
        sid_word[`LDSC_SID_TEF] = tef_q;
        sid_word[`LDSC_SID_NEG1] = neg_q;
        sid_word[`LDSC_SID_NEG2] = neg_q;
        sid_word[`LDSC_SID_LED] = lfault_q;
        cfg_word = '0;
        cfg_word[`LDSC_CFG_W - 1:0] = {fc_q, bc_q, dc_q};
    end

    // word is written one cycle before the toggle flips, and stays
    // put until the next strobe, so the link side sees it settled
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            reload_word_q <= '0;
            reload_tgl_q <= 1'b0;
        end else if (is_decode) begin
            if (do_grst) begin
                reload_word_q <= '0;
            end else if (do_gs) begin
                reload_word_q <= cfg_word;
            end else if (code == `LDSC_CMD_GS_RD) begin
                reload_word_q <= gs_q;
            end else if (code == `LDSC_CMD_CFG_RD) begin
                reload_word_q <= cfg_word;
            end else if (code == `LDSC_CMD_SID_RD || do_errclr) begin
                reload_word_q <= sid_word;
            end else begin
                reload_word_q <= frame_q;
            end
        end else if (st_q == LDSC_ST_RELOAD) begin
            reload_tgl_q <= ~reload_tgl_q;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    ldsc_cw_e cw_q;

    // width decode: bit 198 clear means 12-bit whatever 197 is
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            cw_q <= LDSC_CW_12;
        end else if (!fc_q[`LDSC_FC_CW_HI]) begin
            cw_q <= LDSC_CW_12;
        end else if (!fc_q[`LDSC_FC_CW_LO]) begin
            cw_q <= LDSC_CW_10;
        end else begin
            cw_q <= LDSC_CW_8;
        end
    end

    // field fan-out straight from the latch flops; counter width comes from its own decode flop, one cycle later
    assign o_function_control = fc_q;
    assign o_group_brightness = bc_q;
    assign o_dot_correction = dc_q;
    assign o_grayscale = gs_q;
    assign o_led_fault_mask = fc_q[`LDSC_FC_MASK];
    assign o_edge_speed_select = fc_q[`LDSC_FC_EDGE];
    assign o_open_threshold_select = fc_q[`LDSC_FC_OPEN];
    assign o_short_threshold_select = fc_q[`LDSC_FC_SHORT];
    assign o_neighbour_test_current = fc_q[`LDSC_FC_NCUR];
    assign o_neighbour_test_duration = fc_q[`LDSC_FC_NDUR];
    assign o_counter_width = cw_q;
    assign o_timing_reset_en = fc_q[`LDSC_FC_TRST];
    assign o_auto_repeat_en = fc_q[`LDSC_FC_AREP];
    assign o_correction_span = fc_q[`LDSC_FC_SPAN_B:`LDSC_FC_SPAN_R];
    assign o_thermal_fault_flag = tef_q;
    assign o_led_fault_flag = lfault_q;
    assign o_fault_pulldown_out = 1'b0;
    assign o_fault_pulldown_oe = pd_q;
    assign o_outputs_allowed = allow_q;

endmodule : ldsc_serial_config

// [ldsc_consts.svh]
// Purpose: named constants for the led driver serial config block
// Assumes: included by bare name, after the package
// Notes: positions count from bit 0 of the common shift register
`ifndef LDSC_CONSTS_SVH
`define LDSC_CONSTS_SVH

// ----------------------------------------------------------------
// frame geometry
// ----------------------------------------------------------------
`define LDSC_FRAME_W 288
`define LDSC_CMD_HI 287
`define LDSC_CMD_LO 276
`define LDSC_CFG_W 205
`define LDSC_FC_HI 204
`define LDSC_FC_LO 192
`define LDSC_BC_HI 191
`define LDSC_BC_LO 168
`define LDSC_DC_HI 167
`define LDSC_DC_LO 0

// ----------------------------------------------------------------
// function control bit positions inside the 13-bit field
// ----------------------------------------------------------------
`define LDSC_FC_MASK 12
`define LDSC_FC_EDGE 11
`define LDSC_FC_OPEN 10
`define LDSC_FC_SHORT 9
`define LDSC_FC_NCUR 8
`define LDSC_FC_NDUR 7
`define LDSC_FC_CW_HI 6
`define LDSC_FC_CW_LO 5
`define LDSC_FC_TRST 4
`define LDSC_FC_AREP 3
`define LDSC_FC_SPAN_B 2
`define LDSC_FC_SPAN_G 1
`define LDSC_FC_SPAN_R 0
`define LDSC_FC_RESET 13'h1000

// ----------------------------------------------------------------
// command codes (top 12 bits of a strobe-high frame)
// ----------------------------------------------------------------
`define LDSC_CMD_GS_RD 12'h5AF
`define LDSC_CMD_SID_RD 12'h5A3
`define LDSC_CMD_CFG_RD 12'h5AC
`define LDSC_CMD_NBR 12'h53A
`define LDSC_CMD_SELF 12'h535
`define LDSC_CMD_NEG 12'h55A
`define LDSC_CMD_ERRCLR 12'hA53
`define LDSC_CMD_GRST 12'hA5C

// ----------------------------------------------------------------
// status image positions in the shift register
// ----------------------------------------------------------------
`define LDSC_SID_TEF 215
`define LDSC_SID_NEG1 205
`define LDSC_SID_NEG2 204
`define LDSC_SID_LED 203

`endif

// [ldsc_pkg.sv]
// Purpose: types shared by the led driver serial config block
// Assumes: nothing
// Notes: numeric constants live in ldsc_consts.svh
package ldsc_pkg;

    // grayscale counter width chosen by the function control field
    typedef enum logic [1:0] {
        LDSC_CW_12,
        LDSC_CW_10,
        LDSC_CW_8
    } ldsc_cw_e;

    // states of the frame capture, decode and reload sequence
    typedef enum logic [2:0] {
        LDSC_ST_IDLE,
        LDSC_ST_DECODE,
        LDSC_ST_RELOAD
    } ldsc_st_e;

endpackage : ldsc_pkg

// [ldsc_serial_config_asserts.sv]
// Purpose: port-level checks for the led driver serial config block
// Assumes: ldsc_pkg compiled first; checks run on the system clock only
// Notes: strobe-free stretches prove latches and the thermal flag cannot drift
`timescale 1ns/1ps

module ldsc_serial_config_asserts
    import ldsc_pkg::*;
(
    input wire logic i_clk, // system clock
    input wire logic i_rst, // power-on reset
    input wire logic i_load_strobe, // load strobe pin
    input wire logic i_overtemp, // thermal trip
    input wire logic i_led_fault, // led error input
    input wire logic o_fault_pulldown_out, // fault pin value
    input wire logic o_fault_pulldown_oe, // fault pin pulled low
    input wire logic o_outputs_allowed, // outputs may run
    input wire logic [12:0] o_function_control, // function field
    input wire logic [23:0] o_group_brightness, // brightness bytes
    input wire logic [167:0] o_dot_correction, // correction field
    input wire logic [287:0] o_grayscale, // grayscale latch
    input wire logic o_led_fault_mask, // mask bit
    input wire logic o_edge_speed_select, // edge speed
    input wire logic o_open_threshold_select, // open threshold
    input wire logic o_short_threshold_select, // short threshold
    input wire logic o_neighbour_test_current, // test current
    input wire logic o_neighbour_test_duration, // test time
    input wire ldsc_cw_e o_counter_width, // counter width
    input wire logic o_timing_reset_en, // timing reset mode
    input wire logic o_auto_repeat_en, // auto repeat mode
    input wire logic [2:0] o_correction_span, // b,g,r spans
    input wire logic o_thermal_fault_flag, // thermal flag
    input wire logic o_led_fault_flag // led flag
);
    default clocking dcb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    // ------------------------------------------------------------
    // sequences
    // ------------------------------------------------------------
    // eight strobe-free cycles outlast the whole decode pipeline
    sequence quiet_s;
        (!i_load_strobe)[*8];
    endsequence
    sequence cool_s;
        (!i_overtemp && !o_thermal_fault_flag)[*4];
    endsequence

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_pin_value: assert property (o_fault_pulldown_out == 1'b0)
        else $error("fault pin drive value not low");
    a_pin_cause: assert property (1'b1 |=> o_fault_pulldown_oe ==
        $past(o_thermal_fault_flag | (o_led_fault_flag & ~o_led_fault_mask)))
        else $error("fault pin enable does not follow flags and mask");
    a_fc_fields: assert property ({o_led_fault_mask, o_edge_speed_select,
        o_open_threshold_select, o_short_threshold_select, o_neighbour_test_current,
        o_neighbour_test_duration, o_timing_reset_en, o_auto_repeat_en,
        o_correction_span} == {o_function_control[12:7], o_function_control[4:0]})
        else $error("function bits do not match field");
    a_width_map: assert property (1'b1 |=> o_counter_width ==
        ($past(o_function_control[6]) ? ($past(o_function_control[5]) ? LDSC_CW_8
        : LDSC_CW_10) : LDSC_CW_12))
        else $error("counter width decode wrong");
    a_latch_hold: assert property (quiet_s |=> $stable(o_function_control) &&
        $stable(o_group_brightness) && $stable(o_dot_correction) && $stable(o_grayscale))
        else $error("latch changed without a strobe");
    a_thermal_hold: assert property (quiet_s ##0 o_thermal_fault_flag
        |=> o_thermal_fault_flag)
        else $error("thermal flag cleared without a command");
    a_thermal_off: assert property (o_thermal_fault_flag |=> !o_outputs_allowed)
        else $error("outputs allowed under thermal fault");
    a_thermal_set: assert property (i_overtemp[*4] |=> o_thermal_fault_flag)
        else $error("thermal flag not latched");
    a_allow_back: assert property (cool_s |-> o_outputs_allowed)
        else $error("outputs not allowed when cool");
    a_fault_set: assert property (i_led_fault[*4] |=> o_led_fault_flag)
        else $error("led fault flag not latched");
endmodule : ldsc_serial_config_asserts

bind ldsc_serial_config ldsc_serial_config_asserts ldsc_serial_config_asserts_i (.*);

// [ldsc_host_model.sv]
// Purpose: host side of the serial link: shift clock, data, strobe
// Assumes: shift clock period 6 ns, stopped between frames
// Notes: data changes 1 ns after the falling edge, well clear of the rise
`timescale 1ns/1ps

module ldsc_host_model (
    output logic o_shift_clk, // shift clock, still outside frames
    output logic o_serial_in, // serial data to the device
    output logic o_load_strobe, // load strobe
    input wire logic i_serial_out // serial data from the device
);
    // idle levels before the first frame
    initial begin
        o_shift_clk = 1'b0;
        o_serial_in = 1'b0;
        o_load_strobe = 1'b0;
    end

    // ------------------------------------------------------------
    // one frame, top bit first; mode 0 no strobe, 1 strobe after the
    // last edge, 2 strobe already high at the last edge
    // ------------------------------------------------------------
    task automatic send(input logic [287:0] f, input int mode, output logic [287:0] rx);
        rx = 288'h0;
        for (int i = 287; i >= 0; i--) begin
            #1 o_serial_in = f[i];
            if (i == 0 && mode == 2) o_load_strobe = 1'b1;
            #2 rx = {rx[286:0], i_serial_out};
            o_shift_clk = 1'b1;
            #3 o_shift_clk = 1'b0;
        end
        // no pull on the data line, so do not leave the last bit showing
        #1 o_serial_in = ~f[0];
        if (mode != 0) begin
            #4 o_load_strobe = 1'b1;
            #40 o_load_strobe = 1'b0;
            #48; // clock stays idle while the device decodes
        end
    endtask : send
endmodule : ldsc_host_model

// [ldsc_serial_config_test.sv]
// Purpose: self-checking bench for the led driver serial config block
// Assumes: host model drives the link; bench drives fault inputs
// Notes: expected values come from the frames the bench builds
`timescale 1ns/1ps
`include "ldsc_consts.svh"

module ldsc_serial_config_test import ldsc_pkg::*;;
    logic i_clk, i_rst, i_overtemp, i_led_fault, shift_clk, serial_in, load_strobe;
    logic serial_out, pd_out, pd_oe, allowed, mask, edge_sel, open_sel, short_sel;
    logic ncur, ndur, trst, arep, tflag, lflag;
    logic [2:0] span;
    logic [12:0] fc_o, last_fc;
    logic [23:0] bc_o;
    logic [167:0] dc_o;
    logic [287:0] gs_o, rx;
    ldsc_cw_e cw_o;
    int n_errors, compares;
    localparam logic [287:0] FA = {36{8'hC3}};
    localparam logic [287:0] FB = {36{8'h5A}};
    localparam logic [287:0] FC3 = {72{4'h9}};

    ldsc_serial_config ldsc_serial_config_i (.i_clk(i_clk), .i_rst(i_rst),
        .i_shift_clk(shift_clk), .i_serial_in(serial_in), .i_load_strobe(load_strobe),
        .i_overtemp(i_overtemp), .i_led_fault(i_led_fault), .o_serial_out(serial_out),
        .o_fault_pulldown_out(pd_out), .o_fault_pulldown_oe(pd_oe),
        .o_outputs_allowed(allowed), .o_function_control(fc_o), .o_group_brightness(bc_o),
        .o_dot_correction(dc_o), .o_grayscale(gs_o), .o_led_fault_mask(mask),
        .o_edge_speed_select(edge_sel), .o_open_threshold_select(open_sel),
        .o_short_threshold_select(short_sel), .o_neighbour_test_current(ncur),
        .o_neighbour_test_duration(ndur), .o_counter_width(cw_o), .o_timing_reset_en(trst),
        .o_auto_repeat_en(arep), .o_correction_span(span),
        .o_thermal_fault_flag(tflag), .o_led_fault_flag(lflag));
    ldsc_host_model ldsc_host_model_i (.o_shift_clk(shift_clk), .o_serial_in(serial_in),
        .o_load_strobe(load_strobe), .i_serial_out(serial_out));

    // ------------------------------------------------------------
    // clock and helpers
    // ------------------------------------------------------------
    initial i_clk = 1'b0;
    always #2 i_clk = ~i_clk;

    task automatic check(input string name, input logic [287:0] seen, input logic [287:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic print_verdict;
        if (n_errors == 0 && compares > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : print_verdict

    // ignored middle bits all ones, so a sloppy decode shows up
    function automatic logic [287:0] cfg(input logic [11:0] code, input logic [12:0] fc,
                                         input logic [23:0] bc, input logic [167:0] dc);
        return {code, {71{1'b1}}, fc, bc, dc};
    endfunction : cfg

    task automatic put(input logic [287:0] f, input int mode);
        ldsc_host_model_i.send(f, mode, rx);
        @(posedge i_clk) #1;
    endtask : put

    // bounded wait on a flag; a miss ends the run
    task automatic wait_flag(input int sel, input logic val);
        for (int k = 0; k < 20; k++) begin
            @(posedge i_clk) #1;
            if ((sel == 0 ? lflag : tflag) === val) return;
        end
        n_errors++;
        print_verdict();
    endtask : wait_flag

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic s_power_on;
        check("fc reset", fc_o, `LDSC_FC_RESET);
        check("bc dc reset", {bc_o, dc_o}, 192'h0);
        check("gs reset", gs_o, 288'h0);
        check("width reset", cw_o, LDSC_CW_12);
        check("flags reset", {tflag, lflag, pd_oe}, 3'h0);
        put(FA, 0);
        check("first shift out", rx, 288'h0);
        put(FB, 0);
        check("second shift out", rx, FA);
        put(FC3, 1);
        check("gs write", gs_o, FC3);
        check("fc after gs", fc_o, `LDSC_FC_RESET);
        put(cfg(`LDSC_CMD_ERRCLR, 13'h0, 24'h0, 168'h0), 2);
        check("cfg readback", rx, {FC3[287:285], 285'(`LDSC_FC_RESET) << `LDSC_FC_LO});
        put(cfg(`LDSC_CMD_GRST, 13'h0, 24'h0, 168'h0), 2);
    endtask : s_power_on

    task automatic s_config;
        logic [12:0] fc;
        logic [23:0] bc;
        logic [167:0] dc;
        for (int i = 0; i < 4; i++) begin
            fc = 13'h0F9F;
            fc[6:5] = i[1:0];
            bc = 24'hC3_A55A + 24'(i);
            dc = {24{7'h2B}} ^ 168'(i);
            put(cfg(12'h000, fc, bc, dc), 2);
            check("fc write", fc_o, fc);
            check("bc write", bc_o, bc);
            check("dc write", dc_o, dc);
            check("gs kept", gs_o, 288'h0);
            check("width", cw_o, i == 2 ? LDSC_CW_10 : i == 3 ? LDSC_CW_8 : LDSC_CW_12);
            check("selects", {mask, edge_sel, open_sel, short_sel, ncur, ndur},
                  fc[12:7]);
            check("modes", {trst, arep, span}, fc[4:0]);
        end
        last_fc = 13'h1A53;
        put(cfg(12'h123, last_fc, 24'h00_0011, 168'h0), 2);
        check("unknown code", fc_o, last_fc);
    endtask : s_config

    task automatic s_commands;
        logic [11:0] codes [7];
        codes = '{`LDSC_CMD_GS_RD, `LDSC_CMD_SID_RD, `LDSC_CMD_CFG_RD, `LDSC_CMD_NBR,
                  `LDSC_CMD_SELF, `LDSC_CMD_NEG, `LDSC_CMD_ERRCLR};
        foreach (codes[i]) begin
            put(cfg(codes[i], 13'h0555, 24'hFF_FFFF, 168'h0), 2);
            check("fc under command", fc_o, last_fc);
            check("bc under command", bc_o, 24'h00_0011);
        end
        put(cfg(`LDSC_CMD_GRST, 13'h0555, 24'hFF_FFFF, 168'h0), 2);
        check("fc global reset", fc_o, `LDSC_FC_RESET);
        check("bc dc global reset", {bc_o, dc_o}, 192'h0);
        check("gs global reset", gs_o, 288'h0);
    endtask : s_commands

    task automatic s_faults;
        i_led_fault = 1'b1;
        wait_flag(0, 1'b1);
        repeat (2) @(posedge i_clk) #1;
        check("masked fault pin", pd_oe, 1'b0);
        put(cfg(12'h000, 13'h0000, 24'h0, 168'h0), 2);
        check("unmasked fault pin", pd_oe, 1'b1);
        i_led_fault = 1'b0;
        repeat (4) @(posedge i_clk) #1;
        put(cfg(`LDSC_CMD_ERRCLR, 13'h0, 24'h0, 168'h0), 2);
        check("led flag cleared", {lflag, pd_oe}, 2'h0);
        i_overtemp = 1'b1;
        wait_flag(1, 1'b1);
        repeat (2) @(posedge i_clk) #1;
        check("outputs off hot", allowed, 1'b0);
        check("fc kept hot", fc_o, 13'h0000);
        i_overtemp = 1'b0;
        repeat (8) @(posedge i_clk) #1;
        check("thermal flag sticky", {tflag, allowed, pd_oe}, 3'b101);
        put(cfg(`LDSC_CMD_ERRCLR, 13'h0, 24'h0, 168'h0), 2);
        check("thermal cleared", {tflag, allowed}, 2'b01);
        put(cfg(`LDSC_CMD_GRST, 13'h0, 24'h0, 168'h0), 2);
        check("fc after init", fc_o, `LDSC_FC_RESET);
    endtask : s_faults

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        i_rst = 1'b1;
        i_overtemp = 1'b0;
        i_led_fault = 1'b0;
        n_errors = 0;
        compares = 0;
        last_fc = 13'h0;
        repeat (6) @(posedge i_clk);
        #1 i_rst = 1'b0;
        repeat (3) @(posedge i_clk);
        #1;
        s_power_on();
        s_config();
        s_commands();
        s_faults();
        print_verdict();
    end
endmodule : ldsc_serial_config_test
